// File: ddr2_pin_command_interface_tb.sv
// Bench joining controller end and device end across the pin bundle.
// Assumes the controller makes the link clock from core_clk.
`timescale 1ns/1ps
module ddr2_pin_command_interface_tb;
    logic        core_clk;
    logic        rst_b;
    logic        req_valid;
    logic [2:0]  req_cmd;
    logic [2:0]  req_bank;
    logic [13:0] req_addr;
    logic [15:0] req_wdata;
    logic [1:0]  req_mask;
    logic        req_clk_en;
    logic        req_term;
    logic        req_ready;
    logic [1:0]  power_state;
    logic [13:0] ext_cfg;
    logic [7:0]  open_banks;
    int          mismatches;
    int          n_checks;
    mem_pin_if pins ();
    // Resolve two-way lines; a released bus shows inverted data, not a stale copy
    assign pins.dq_i = pins.dq_dev_oe ? pins.dq_dev_o :
                       (pins.dq_ctl_oe ? pins.dq_ctl_o : ~pins.dq_ctl_o);
    assign pins.strobe_i = pins.strobe_dev_oe ? pins.strobe_dev_o :
                           (pins.strobe_ctl_oe ? pins.strobe_ctl_o : ~pins.strobe_ctl_o);
    mem_ctl_end u_mem_ctl_end (.core_clk(core_clk), .rst_b(rst_b), .pins(pins.controller),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_mask(req_mask), .req_clk_en(req_clk_en),
        .req_term(req_term), .req_ready(req_ready));
    mem_device_end u_mem_device_end (.pins(pins.device), .power_state(power_state),
        .ext_cfg(ext_cfg), .open_banks(open_banks));
    mem_pin_properties u_mem_pin_properties (.clk_true(pins.clk_true), .rst_b(rst_b),
        .clk_en(pins.clk_en), .chip_sel_n(pins.chip_sel_n), .row_strobe_n(pins.row_strobe_n),
        .col_strobe_n(pins.col_strobe_n), .wr_strobe_n(pins.wr_strobe_n),
        .termination_ctl(pins.termination_ctl), .bank_select(pins.bank_select),
        .addr(pins.addr), .dq_dev_oe(pins.dq_dev_oe), .strobe_dev_oe(pins.strobe_dev_oe),
        .strobe_dev_n_oe(pins.strobe_dev_n_oe), .read_copy_oe(pins.read_copy_oe),
        .term_on(pins.term_on), .power_state(power_state), .ext_cfg(ext_cfg),
        .open_banks(open_banks));
    // Clock at 4 ns
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One request held to the edge after ready, then time for the device to act
    task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a,
                         input logic [15:0] d, input logic [1:0] m);
        int n;
        {req_valid, req_cmd, req_bank, req_addr, req_wdata, req_mask} = {1'b1, c, b, a, d, m};
        for (n = 0; n < 40 && req_ready !== 1'b1; n++) begin
            @(posedge core_clk) #1;
        end
        @(posedge core_clk) #1;
        req_valid = 1'b0;
        repeat (16) @(posedge core_clk) #1;
    endtask
    task automatic t_cfg_term();
        issue(mem_pin_pkg::CMD_LOAD_CFG, mem_pin_pkg::SEL_EXT, 14'h0804, 16'h0, 2'h0);
        chk({2'h0, ext_cfg}, 16'h0804);
        issue(mem_pin_pkg::CMD_LOAD_CFG, mem_pin_pkg::SEL_BASE, 14'h0123, 16'h0, 2'h0);
        chk({2'h0, ext_cfg}, 16'h0804);
        req_term = 1'b1;
        issue(mem_pin_pkg::CMD_NOP, 3'h0, 14'h0, 16'h0, 2'h0);
        chk({15'h0, pins.term_on}, 16'h1);
        req_term = 1'b0;
    endtask
    task automatic t_banks();
        // Device has no reset: close all banks first so the view is known
        issue(mem_pin_pkg::CMD_PRECHARGE, 3'h0, 14'h0400, 16'h0, 2'h0);
        issue(mem_pin_pkg::CMD_ACTIVATE, 3'h5, 14'h0011, 16'h0, 2'h0);
        issue(mem_pin_pkg::CMD_ACTIVATE, 3'h2, 14'h0022, 16'h0, 2'h0);
        chk({8'h0, open_banks}, 16'h0024);
        issue(mem_pin_pkg::CMD_PRECHARGE, 3'h5, 14'h0000, 16'h0, 2'h0);
        chk({8'h0, open_banks}, 16'h0004);
        issue(mem_pin_pkg::CMD_PRECHARGE, 3'h0, 14'h0400, 16'h0, 2'h0);
        chk({8'h0, open_banks}, 16'h0000);
    endtask
    // Idle power-down, then active power-down with bank 0 left open
    task automatic t_power();
        int i;
        for (i = 0; i < 2; i++) begin
            req_clk_en = 1'b0;
            issue(mem_pin_pkg::CMD_NOP, 3'h0, 14'h0, 16'h0, 2'h0);
            chk({14'h0, power_state}, (i == 0) ? 16'h1 : 16'h2);
            req_clk_en = 1'b1;
            issue(mem_pin_pkg::CMD_NOP, 3'h0, 14'h0, 16'h0, 2'h0);
            chk({14'h0, power_state}, 16'h0);
            issue(mem_pin_pkg::CMD_ACTIVATE, 3'h0, 14'h0, 16'h0, 2'h0);
        end
    endtask
    // Full write, then a write with the high lane masked, then read back
    task automatic t_data();
        int n;
        issue(mem_pin_pkg::CMD_WRITE, 3'h0, 14'h0, 16'h1234, 2'h0);
        issue(mem_pin_pkg::CMD_WRITE, 3'h0, 14'h0, 16'habcd, 2'h2);
        fork
            issue(mem_pin_pkg::CMD_READ, 3'h0, 14'h0, 16'h0, 2'h0);
            for (n = 0; n < 40 && pins.dq_dev_oe !== 1'b1; n++) begin
                @(posedge core_clk) #1;
            end
        join_any
        chk(pins.dq_dev_o, 16'h12cd);
        chk({14'h0, pins.strobe_dev_oe, pins.read_copy_oe}, 16'h3);
        chk({15'h0, pins.strobe_dev_n_oe}, 16'h1);
        wait fork;
        issue(mem_pin_pkg::CMD_LOAD_CFG, mem_pin_pkg::SEL_EXT, 14'h0400, 16'h0, 2'h0);
        req_term = 1'b1;
        issue(mem_pin_pkg::CMD_NOP, 3'h0, 14'h0, 16'h0, 2'h0);
        chk({15'h0, pins.term_on}, 16'h0);
    endtask
    initial begin
        {rst_b, req_valid, req_cmd, req_bank, req_addr} = {1'b0, 1'b0, 3'h7, 3'h0, 14'h0};
        {req_wdata, req_mask, req_clk_en, req_term} = {16'h0, 2'h0, 1'b1, 1'b0};
        mismatches = 0;
        n_checks = 0;
        repeat (6) @(posedge core_clk);
        #1 rst_b = 1'b1;
        t_cfg_term();
        t_banks();
        t_power();
        t_data();
        test_done();
    end
    // Watchdog well past the few hundred cycles the tests need
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
endmodule // ddr2_pin_command_interface_tb

// File: mem_ctl_end.sv
// Controller end: issues one command per request, drives write data.
// Assumes core_clk is the link clock source; link clock = core_clk / 2.
`timescale 1ns/1ps
module mem_ctl_end (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Pins toward the device
    mem_pin_if.controller    pins,
    // User request
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_cmd,
    input  wire logic [2:0]  req_bank,
    input  wire logic [13:0] req_addr,
    input  wire logic [15:0] req_wdata,
    input  wire logic [1:0]  req_mask,
    input  wire logic        req_clk_en,
    input  wire logic        req_term,
    output logic             req_ready
);
    logic div;
    // Link clock from a divider; commands change on its falling edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) div <= 1'b0;
        else div <= ~div;
    end
    assign pins.clk_true = div;
    assign pins.clk_comp = ~div;

    // Commands change as clk_true falls so they are stable at its rise
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pins.chip_sel_n <= 1'b1;
            {pins.row_strobe_n, pins.col_strobe_n, pins.wr_strobe_n} <= 3'h7;
            pins.bank_select <= 3'h0;
            pins.addr <= 14'h0000;
            pins.clk_en <= 1'b1;
            pins.termination_ctl <= 1'b0;
            req_ready <= 1'b0;
        end else if (div) begin
            req_ready <= 1'b1;
            pins.clk_en <= req_clk_en;
            pins.termination_ctl <= req_term;
            pins.chip_sel_n <= !req_valid;
            {pins.row_strobe_n, pins.col_strobe_n, pins.wr_strobe_n} <= req_cmd;
            pins.bank_select <= req_bank;
            pins.addr <= req_addr;
        end else begin
            req_ready <= 1'b0;
        end
    end

    logic [3:0] wr_hold;
    // Data and masks latched with the write command and held for the whole burst
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pins.dq_ctl_o <= 16'h0000;
            pins.low_byte_mask <= 1'b0;
            pins.high_byte_mask <= 1'b0;
            wr_hold <= 4'h0;
        end else if (div && req_valid && req_cmd == mem_pin_pkg::CMD_WRITE) begin
            pins.dq_ctl_o <= req_wdata;
            pins.low_byte_mask <= req_mask[0];
            pins.high_byte_mask <= req_mask[1];
            wr_hold <= 4'(2 * mem_pin_pkg::BURST + 2);
        end else if (wr_hold != 4'h0) begin
            wr_hold <= wr_hold - 4'h1;
        end
    end
    assign pins.dq_ctl_oe = wr_hold != 4'h0;
    assign pins.strobe_ctl_oe = wr_hold != 4'h0;
    // Strobe moves on the falling core edge so its edges sit mid-beat
    always_ff @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) pins.strobe_ctl_o <= 2'h0;
        else if (wr_hold != 4'h0) pins.strobe_ctl_o <= ~pins.strobe_ctl_o;
        else pins.strobe_ctl_o <= 2'h0; // Parked outside bursts, no stray edges
    end
endmodule // mem_ctl_end

// File: mem_device_end.sv
// DRAM device end: command decode, bank state, configuration registers,
// termination, power states and a small data store.
// Summary of operation
// - Termination on when control sampled high
// - Termination control ignored when disabled
// - Sample command pins on rising true clock
// - Clock-enable low: power-down or self refresh
// - Every exit asynchronous on enable rise, entries synchronous
// - Power-down: only clock, enable, termination listened
// - Self refresh: only clock-enable listened
// - Chip select high masks every command
// - Command from three strobes plus select
// - Masked write beats are not stored
// - Masks per byte lane, both strobe edges
// - Bank select names command target bank
// - Bank select picks configuration register
// - Row on activate, column plus autoclose bit
// - Autoclose bit picks one or all banks
// - Address carries configuration opcode
// - Read strobe edge-aligned; write strobe centered
// - Complement strobe only in differential mode
// - Read copy strobe only with reads
// - Read copy complement needs both enables
// - Extended bit ten turns complements off
// - Write data captured on both strobe edges
// Assumes the link clock and the write strobe are the only clocks; the controller meets pin setup.
`timescale 1ns/1ps
module mem_device_end #(
    parameter int DEPTH = 16
) (
    // Pins toward the controller
    mem_pin_if.device pins,
    // User side: power state and configuration view
    output logic [1:0]  power_state,
    output logic [13:0] ext_cfg,
    output logic [7:0]  open_banks
);
    typedef enum logic [1:0] {
        ST_ON   = 2'b00,
        ST_PPD  = 2'b01,
        ST_APD  = 2'b10,
        ST_SELF = 2'b11
    } pwr_t;

    initial begin
        if (DEPTH < 2 || DEPTH > 1024) $error("DEPTH out of range");
    end

    localparam int AW = $clog2(DEPTH);
    logic        clk;
    pwr_t        pwr;
    logic [13:0] cfg [mem_pin_pkg::NUM_CFG];
    logic [15:0] store [DEPTH];
    logic        cs_ok;
    logic [2:0]  cmd;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [2:0]  wr_left;
    logic [mem_pin_pkg::RD_LAT+mem_pin_pkg::BURST-1:0] rd_pipe;
    logic        rd_active;

    assign clk = pins.clk_true;
    assign cmd = {pins.row_strobe_n, pins.col_strobe_n, pins.wr_strobe_n};
    // Decoder listens only when awake and selected
    assign cs_ok = !pins.chip_sel_n && pwr == ST_ON && pins.clk_en;

    function automatic logic [AW-1:0] col_index(input logic [13:0] a);
        col_index = a[AW-1:0];
    endfunction

    // Entry waits for a rising clock; a rising enable wakes at once, which also
    // gives the state a known value, since the device has no reset pin
    always_ff @(posedge clk or posedge pins.clk_en) begin
        if (pins.clk_en) begin
            pwr <= ST_ON; // Self refresh exits without waiting on a clock edge
        end else if (pwr == ST_ON) begin
            if (open_banks != 8'h00) pwr <= ST_APD;
            else if (!pins.chip_sel_n && cmd == mem_pin_pkg::CMD_REFRESH)
                pwr <= ST_SELF;
            else pwr <= ST_PPD;
        end
    end

    // Configuration loads: bank select picks register, address is opcode
    always_ff @(posedge clk) begin
        if (cs_ok && cmd == mem_pin_pkg::CMD_LOAD_CFG) begin
            cfg[pins.bank_select[1:0]] <= pins.addr;
        end
    end

    // Open row tracking per bank
    always_ff @(posedge clk) begin
        if (cs_ok && cmd == mem_pin_pkg::CMD_ACTIVATE) begin
            open_banks[pins.bank_select] <= 1'b1;
        end else if (cs_ok && cmd == mem_pin_pkg::CMD_PRECHARGE) begin
            if (pins.addr[mem_pin_pkg::AUTOCLOSE_POS]) open_banks <= 8'h00;
            else open_banks[pins.bank_select] <= 1'b0;
        end else if (cs_ok && (cmd == mem_pin_pkg::CMD_READ || cmd == mem_pin_pkg::CMD_WRITE)
                     && pins.addr[mem_pin_pkg::AUTOCLOSE_POS]) begin
            open_banks[pins.bank_select] <= 1'b0; // Autoclose at the command edge, not after the burst
        end
    end

    // Termination: enabled by config, sampled on the clock, kept in power-down
    always_ff @(posedge clk) begin
        if (pwr == ST_SELF) pins.term_on <= 1'b0;
        else pins.term_on <= pins.termination_ctl && (ext_cfg[mem_pin_pkg::EXT_TERM_LO_POS]
                             || ext_cfg[mem_pin_pkg::EXT_TERM_HI_POS]);
    end

    assign ext_cfg = cfg[mem_pin_pkg::SEL_EXT[1:0]];
    assign power_state = pwr;

    // Write burst bookkeeping
    always_ff @(posedge clk) begin
        if (cs_ok && cmd == mem_pin_pkg::CMD_WRITE) begin
            wr_left <= 3'(mem_pin_pkg::BURST);
            wr_ptr  <= col_index(pins.addr);
        end else if (wr_left != 3'h0) begin
            wr_left <= wr_left - 3'h1;
        end
    end

    // Data captured on each strobe edge; masked lanes left untouched
    always_ff @(posedge pins.strobe_i[0] or negedge pins.strobe_i[0]) begin
        if (wr_left != 3'h0) begin
            if (!pins.low_byte_mask) store[wr_ptr][7:0] <= pins.dq_i[7:0];
            if (!pins.high_byte_mask) store[wr_ptr][15:8] <= pins.dq_i[15:8];
        end
    end

    // Read pipeline: fixed latency then one beat per cycle
    always_ff @(posedge clk) begin
        rd_pipe <= {rd_pipe[$bits(rd_pipe)-2:0], 1'b0};
        if (cs_ok && cmd == mem_pin_pkg::CMD_READ) begin
            rd_pipe[0] <= 1'b1;
            rd_ptr     <= col_index(pins.addr);
        end
    end
    assign rd_active = |rd_pipe[$bits(rd_pipe)-1:mem_pin_pkg::RD_LAT];

    // Read drivers: strobe follows the clock, edge-aligned with data
    always_comb begin
        pins.dq_dev_o      = store[rd_ptr];
        pins.dq_dev_oe     = rd_active;
        pins.strobe_dev_o  = {2{clk & rd_active}};
        pins.strobe_dev_oe = rd_active;
        pins.strobe_dev_n_o  = ~pins.strobe_dev_o;
        pins.strobe_dev_n_oe = rd_active && !ext_cfg[mem_pin_pkg::EXT_COMP_OFF_POS];
        pins.read_copy_strobe   = clk & rd_active;
        pins.read_copy_oe       = rd_active && ext_cfg[mem_pin_pkg::EXT_RDCOPY_POS];
        pins.read_copy_strobe_n = !(clk & rd_active) && !ext_cfg[mem_pin_pkg::EXT_COMP_OFF_POS]
                                  && ext_cfg[mem_pin_pkg::EXT_RDCOPY_POS];
    end
endmodule // mem_device_end

// File: mem_pin_if.sv
// Pin bundle between memory controller and DRAM device.
// Assumes the bench resolves two-way pins from the enables.
`timescale 1ns/1ps
interface mem_pin_if;
    logic        clk_true;
    logic        clk_comp;
    logic        clk_en;
    logic        chip_sel_n;
    logic        row_strobe_n;
    logic        col_strobe_n;
    logic        wr_strobe_n;
    logic        termination_ctl;
    logic [2:0]  bank_select;
    logic [13:0] addr;
    logic        low_byte_mask;
    logic        high_byte_mask;
    logic [15:0] dq_ctl_o;
    logic        dq_ctl_oe;
    logic [15:0] dq_dev_o;
    logic        dq_dev_oe;
    logic [15:0] dq_i;
    logic [1:0]  strobe_ctl_o;
    logic        strobe_ctl_oe;
    logic [1:0]  strobe_dev_o;
    logic [1:0]  strobe_dev_n_o;
    logic        strobe_dev_oe;
    logic        strobe_dev_n_oe;
    logic [1:0]  strobe_i;
    logic        read_copy_strobe;
    logic        read_copy_strobe_n;
    logic        read_copy_oe;
    logic        term_on;
    modport device (
        input  clk_true, clk_comp, clk_en, chip_sel_n, row_strobe_n, col_strobe_n,
        input  wr_strobe_n, termination_ctl, bank_select, addr,
        input  low_byte_mask, high_byte_mask, dq_i, strobe_i,
        output dq_dev_o, dq_dev_oe, strobe_dev_o, strobe_dev_n_o, strobe_dev_oe,
        output strobe_dev_n_oe, read_copy_strobe, read_copy_strobe_n, read_copy_oe,
        output term_on
    );
    modport controller (
        output clk_true, clk_comp, clk_en, chip_sel_n, row_strobe_n, col_strobe_n,
        output wr_strobe_n, termination_ctl, bank_select, addr,
        output low_byte_mask, high_byte_mask, dq_ctl_o, dq_ctl_oe,
        output strobe_ctl_o, strobe_ctl_oe,
        input  dq_i, strobe_i
    );
endinterface

// File: mem_pin_pkg.sv
// Shared constants for the DRAM pin interface: command codes, widths,
// configuration register selects and bit positions.
// Assumes nothing beyond a SystemVerilog compiler.
package mem_pin_pkg;
    localparam int BANK_W   = 3;
    localparam int ADDR_W   = 14;
    localparam int DATA_W   = 16;
    localparam int NUM_BANK = 8;
    localparam int NUM_CFG  = 4;
    // Command codes {row, column, write strobe}, all active low
    localparam logic [2:0] CMD_LOAD_CFG  = 3'h0;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_NOP       = 3'h7;
    // Configuration register selects on bank_select
    localparam logic [2:0] SEL_BASE = 3'h0;
    localparam logic [2:0] SEL_EXT  = 3'h1;
    // Bit positions in the extended register and the address bus
    localparam int AUTOCLOSE_POS    = 10;
    localparam int EXT_TERM_LO_POS  = 2;
    localparam int EXT_TERM_HI_POS  = 6;
    localparam int EXT_COMP_OFF_POS = 10;
    localparam int EXT_RDCOPY_POS   = 11;
    localparam logic [13:0] EXT_RESET = 14'h0000;
    localparam int BYTE_W = 8;
    // Fixed read latency in link clocks, and burst length in beats
    localparam int RD_LAT = 3;
    localparam int BURST  = 4;
    localparam int FF_ONE = 1;
endpackage

// File: mem_pin_properties.sv
// Checker for the DRAM pin bundle, watching what the device end drives.
// Assumes the bench places it beside the interface joining both ends.
`timescale 1ns/1ps
module mem_pin_properties (
    // Link clock and reset
    input wire logic        clk_true,
    input wire logic        rst_b,
    // Command pins
    input wire logic        clk_en,
    input wire logic        chip_sel_n,
    input wire logic        row_strobe_n,
    input wire logic        col_strobe_n,
    input wire logic        wr_strobe_n,
    input wire logic        termination_ctl,
    input wire logic [2:0]  bank_select,
    input wire logic [13:0] addr,
    // Device drive enables
    input wire logic        dq_dev_oe,
    input wire logic        strobe_dev_oe,
    input wire logic        strobe_dev_n_oe,
    input wire logic        read_copy_oe,
    input wire logic        term_on,
    // Device user side
    input wire logic [1:0]  power_state,
    input wire logic [13:0] ext_cfg,
    input wire logic [7:0]  open_banks
);
    logic [2:0]  cmd;
    logic        live;
    logic [13:0] cfg_v;
    default clocking @(posedge clk_true); endclocking
    default disable iff (!rst_b);
    // A command only counts when selected and powered up
    assign cmd  = {row_strobe_n, col_strobe_n, wr_strobe_n};
    assign live = !chip_sel_n && clk_en && power_state == 2'h0;
    // Keep the last opcode, since the pins move on before the view updates
    always_ff @(posedge clk_true) begin
        if (live && cmd == mem_pin_pkg::CMD_LOAD_CFG)
            cfg_v <= addr;
    end
    AST_CFG_LOAD: assert property (
        live && cmd == mem_pin_pkg::CMD_LOAD_CFG && bank_select == mem_pin_pkg::SEL_EXT
        |-> ##[1:2] ext_cfg == cfg_v) else $error("extended config not loaded");
    AST_ACT_BANK: assert property (
        live && cmd == mem_pin_pkg::CMD_ACTIVATE && bank_select == 3'h5
        |-> ##[1:2] open_banks[5]) else $error("activate missed bank");
    AST_PRE_ONE: assert property (
        live && cmd == mem_pin_pkg::CMD_PRECHARGE && !addr[10] && bank_select == 3'h5
        |-> ##[1:2] !open_banks[5]) else $error("single close missed");
    AST_PRE_ALL: assert property (
        live && cmd == mem_pin_pkg::CMD_PRECHARGE && addr[10]
        |-> ##[1:2] open_banks == 8'h00) else $error("close all missed");
    AST_PWR_IDLE: assert property (
        !clk_en && power_state == 2'h0 && open_banks == 8'h00
        |-> ##[1:3] (power_state == 2'h1 || power_state == 2'h3)) else $error("no power-down");
    AST_TERM_ON: assert property (
        termination_ctl && ext_cfg[mem_pin_pkg::EXT_TERM_LO_POS] && power_state != 2'h3
        |-> ##[0:2] term_on) else $error("termination not enabled");
    AST_TERM_OFF: assert property (
        (!ext_cfg[mem_pin_pkg::EXT_TERM_LO_POS] && !ext_cfg[mem_pin_pkg::EXT_TERM_HI_POS]) [*3]
        |-> !term_on) else $error("termination on while disabled");
    AST_COMP_OFF: assert property (
        ext_cfg[mem_pin_pkg::EXT_COMP_OFF_POS] [*2] |-> !strobe_dev_n_oe)
        else $error("complement strobe driven");
    AST_RD_STROBE: assert property (
        dq_dev_oe |-> strobe_dev_oe) else $error("read data without strobe");
    AST_RD_COPY: assert property (
        read_copy_oe |-> dq_dev_oe) else $error("read copy strobe outside reads");
endmodule // mem_pin_properties
